// File: common/jrhb_regs.svh
// Constants for the register jump and hazard barrier control block.
// Assumes a 32-bit instruction word and a 32-bit general register file.
`ifndef JRHB_REGS_SVH
`define JRHB_REGS_SVH

`define JRHB_OPC_MSB 31
`define JRHB_OPC_LSB 26
`define JRHB_SRC_MSB 25
`define JRHB_SRC_LSB 21
`define JRHB_RT_MSB 20
`define JRHB_RT_LSB 16
`define JRHB_RD_MSB 15
`define JRHB_RD_LSB 11
`define JRHB_SA_MSB 10
`define JRHB_SA_LSB 6
`define JRHB_FN_MSB 5
`define JRHB_FN_LSB 0
`define JRHB_HINT_BARRIER_BIT 10

`define JRHB_OPC_A 6'h00
`define JRHB_OPC_REGIMM 6'h01
`define JRHB_OPC_COP0 6'h10
`define JRHB_FN_JUMP_REG 6'h08
`define JRHB_FN_JUMP_LINK_REG 6'h09
`define JRHB_FN_SLL 6'h00
`define JRHB_FN_EXC_RETURN 6'h18
`define JRHB_FN_DBG_RETURN 6'h1F
`define JRHB_FN_WAIT 6'h20
`define JRHB_SA_PAUSE 5'h05
`define JRHB_REG_ZERO 5'h00
`define JRHB_HINT_PLAIN 5'h00

`define JRHB_ISA_MODE_RST 1'h0
`define JRHB_OUTSTANDING_RST 4'h0
`define JRHB_REDIRECT_LAT 1

`endif

// File: common/jrhb_pkg.sv
// Types for the register jump and hazard barrier control block.
// Assumes the constants header is compiled alongside.
package jrhb_pkg;

  typedef enum logic [1:0] {
    JRHB_IDLE,
    JRHB_SLOT,
    JRHB_DRAIN
  } jrhb_state_t;

endpackage : jrhb_pkg

// File: rtl/jrhb_hazard_tracker.sv
// Counts system-coprocessor and TLB writes that are still in flight.
// Assumes writes complete in issue order, one issue and one done per cycle.
`timescale 1ns/1ps
`include "jrhb_regs.svh"

module jrhb_hazard_tracker #(
  parameter int CNT_W = 4
) (
  input wire logic i_clk, // core clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_hz_issue, // hazard-causing write issued
  input wire logic i_hz_done, // hazard-causing write took effect
  input wire logic i_snapshot, // capture writes older than the jump
  output logic o_clear // no captured write remains
);

  logic [CNT_W-1:0] outstanding;
  logic [CNT_W-1:0] remaining;
  logic [CNT_W-1:0] next_outstanding;
  logic [CNT_W-1:0] next_remaining;

  always_comb begin
    next_outstanding = outstanding;
    if (i_hz_issue && !i_hz_done) begin
      next_outstanding = outstanding + CNT_W'(1);
    end else if (!i_hz_issue && i_hz_done && outstanding != '0) begin
      next_outstanding = outstanding - CNT_W'(1);
    end
    // Writes issued after the snapshot belong to the delay slot and are
    // not waited for; only the older ones are counted down.
    if (i_snapshot) begin
      next_remaining = next_outstanding;
    end else if (i_hz_done && remaining != '0) begin
      next_remaining = remaining - CNT_W'(1);
    end else begin
      next_remaining = remaining;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      outstanding <= CNT_W'(`JRHB_OUTSTANDING_RST);
      remaining <= CNT_W'(`JRHB_OUTSTANDING_RST);
    end else begin
      outstanding <= next_outstanding;
      remaining <= next_remaining;
    end
  end

  assign o_clear = (remaining == '0);

endmodule : jrhb_hazard_tracker

// File: rtl/jrhb_jump_ctrl.sv
// Register jump control with optional hazard barrier and delay slot.
// Assumes one instruction per valid cycle, in program order, with the
// source register value supplied in the same cycle as the instruction.
`timescale 1ns/1ps
`include "jrhb_regs.svh"

module jrhb_jump_ctrl #(
  parameter int CNT_W = 4
) (
  input wire logic i_clk, // core clock, 40 MHz
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_instr_valid, // instruction executes this cycle
  input wire logic [31:0] i_instr, // instruction word
  input wire logic [31:0] i_src_value, // general_register read data
  input wire logic i_release6, // newer encoding and slot checks
  input wire logic [1:0] i_compressed_set_cfg, // compressed_set_cfg field
  input wire logic i_code_compress_cfg, // code_compress_cfg bit
  input wire logic i_hz_issue, // hazard-causing write issued
  input wire logic i_hz_done, // hazard-causing write took effect
  output logic [4:0] o_src_reg_sel, // source_reg_field read select
  output logic o_redirect, // fetch target now, one-cycle pulse
  output logic [31:0] o_redirect_pc, // target fetch address
  output logic o_isa_mode_bit, // isa_mode_bit for the target
  output logic o_addr_error, // address error at target fetch
  output logic o_reserved_instr, // control transfer in delay slot
  output logic o_flush_younger, // drop fetched younger instructions
  output logic o_fetch_stall, // hold fetch while draining hazards
  output logic o_link_we, // write link register
  output logic [4:0] o_link_reg, // link destination register
  output logic o_busy // jump in progress
);

  typedef struct packed {
    logic [31:0] pc;
    logic mode;
    logic err;
  } jrhb_tgt_t;

  jrhb_pkg::jrhb_state_t state;
  jrhb_pkg::jrhb_state_t next_state;
  logic [31:0] temp;
  logic [31:0] next_temp;
  logic barrier;
  logic next_barrier;
  logic redirect, next_redirect;
  logic [31:0] redirect_pc, next_redirect_pc;
  logic isa_mode, next_isa_mode;
  logic addr_error, next_addr_error;
  logic resv, next_resv;
  logic flush, next_flush;
  logic link_we, next_link_we;
  logic [4:0] link_reg, next_link_reg;
  logic snapshot;
  logic hz_clear;
  logic compressed;
  logic is_jump;
  logic is_barrier;
  logic [4:0] rd_field;
  jrhb_tgt_t tgt;

  // Is this word any branch, jump, return, wait or pause.
  function automatic logic is_ctl_xfer(input logic [31:0] w);
    logic [5:0] op;
    logic [5:0] fn;
    op = w[`JRHB_OPC_MSB:`JRHB_OPC_LSB];
    fn = w[`JRHB_FN_MSB:`JRHB_FN_LSB];
    is_ctl_xfer = 1'b0;
    if (op == `JRHB_OPC_A) begin
      if (fn == `JRHB_FN_JUMP_REG || fn == `JRHB_FN_JUMP_LINK_REG) begin
        is_ctl_xfer = 1'b1;
      end
      if (fn == `JRHB_FN_SLL && w[25:11] == 15'h0000 &&
          w[`JRHB_SA_MSB:`JRHB_SA_LSB] == `JRHB_SA_PAUSE) begin
        is_ctl_xfer = 1'b1;
      end
    end else if (op == `JRHB_OPC_REGIMM) begin
      is_ctl_xfer = 1'b1;
    end else if (op == `JRHB_OPC_COP0) begin
      if (w[25] && (fn == `JRHB_FN_EXC_RETURN ||
          fn == `JRHB_FN_DBG_RETURN || fn == `JRHB_FN_WAIT)) begin
        is_ctl_xfer = 1'b1;
      end
    end else if (op[5:2] == 4'h1 || op[5:1] == 5'h01 ||
                 op[5:2] == 4'h5 || op[5:1] == 5'h1B ||
                 op[5:1] == 5'h1F || op == 6'h32 || op == 6'h3A) begin
      // Jumps, branches, likely branches and compact forms.
      is_ctl_xfer = 1'b1;
    end
  endfunction : is_ctl_xfer

  // Fetch address, new mode and alignment fault for a register value.
  function automatic jrhb_tgt_t calc_target(input logic [31:0] v,
                                            input logic cmp);
    jrhb_tgt_t t;
    if (!cmp) begin
      t.pc = v;
      t.mode = `JRHB_ISA_MODE_RST;
      t.err = (v[1:0] != 2'h0);
    end else begin
      t.pc = {v[31:1], 1'b0};
      t.mode = v[0];
      t.err = (v[1:0] == 2'h2);
    end
    calc_target = t;
  endfunction : calc_target

  assign compressed = (i_compressed_set_cfg != 2'h0) || i_code_compress_cfg;
  assign rd_field = i_instr[`JRHB_RD_MSB:`JRHB_RD_LSB];
  // Jump to register is the linking form in the newer encoding, and the
  // barrier is accepted without any privilege check.
  assign is_jump = i_instr_valid &&
    i_instr[`JRHB_OPC_MSB:`JRHB_OPC_LSB] == `JRHB_OPC_A &&
    (i_instr[`JRHB_FN_MSB:`JRHB_FN_LSB] == `JRHB_FN_JUMP_LINK_REG ||
     (!i_release6 &&
      i_instr[`JRHB_FN_MSB:`JRHB_FN_LSB] == `JRHB_FN_JUMP_REG));
  assign is_barrier = i_instr[`JRHB_HINT_BARRIER_BIT];
  assign o_src_reg_sel = i_instr[`JRHB_SRC_MSB:`JRHB_SRC_LSB];
  assign snapshot = is_jump && state == jrhb_pkg::JRHB_IDLE && is_barrier;
  assign tgt = calc_target(temp, compressed);

  jrhb_hazard_tracker #(
    .CNT_W(CNT_W)
  ) u_tracker (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_hz_issue(i_hz_issue),
    .i_hz_done(i_hz_done),
    .i_snapshot(snapshot),
    .o_clear(hz_clear)
  );

  always_comb begin
    next_state = state;
    next_temp = temp;
    next_barrier = barrier;
    next_redirect = 1'b0;
    next_redirect_pc = redirect_pc;
    next_isa_mode = isa_mode;
    next_addr_error = 1'b0;
    next_resv = 1'b0;
    next_flush = 1'b0;
    next_link_we = 1'b0;
    next_link_reg = link_reg;
    case (state)
      jrhb_pkg::JRHB_IDLE: begin
        if (is_jump) begin
          next_temp = i_src_value;
          next_barrier = is_barrier;
          next_link_we = (rd_field != `JRHB_REG_ZERO);
          next_link_reg = rd_field;
          next_state = jrhb_pkg::JRHB_SLOT;
        end
      end
      jrhb_pkg::JRHB_SLOT: begin
        if (i_instr_valid) begin
          next_resv = i_release6 && is_ctl_xfer(i_instr);
          next_flush = 1'b1;
          if (barrier && !hz_clear) begin
            next_state = jrhb_pkg::JRHB_DRAIN;
          end else begin
            next_redirect = 1'b1;
            next_redirect_pc = tgt.pc;
            next_isa_mode = tgt.mode;
            next_addr_error = tgt.err;
            next_state = jrhb_pkg::JRHB_IDLE;
          end
        end
      end
      jrhb_pkg::JRHB_DRAIN: begin
        if (hz_clear) begin
          next_redirect = 1'b1;
          next_redirect_pc = tgt.pc;
          next_isa_mode = tgt.mode;
          next_addr_error = tgt.err;
          next_state = jrhb_pkg::JRHB_IDLE;
        end
      end
      default: begin
        next_state = jrhb_pkg::JRHB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= jrhb_pkg::JRHB_IDLE;
      temp <= 32'h00000000;
      barrier <= 1'b0;
      redirect <= 1'b0;
      redirect_pc <= 32'h00000000;
      isa_mode <= `JRHB_ISA_MODE_RST;
      addr_error <= 1'b0;
      resv <= 1'b0;
      flush <= 1'b0;
      link_we <= 1'b0;
      link_reg <= 5'h00;
    end else begin
      state <= next_state;
      temp <= next_temp;
      barrier <= next_barrier;
      redirect <= next_redirect;
      redirect_pc <= next_redirect_pc;
      isa_mode <= next_isa_mode;
      addr_error <= next_addr_error;
      resv <= next_resv;
      flush <= next_flush;
      link_we <= next_link_we;
      link_reg <= next_link_reg;
    end
  end

  assign o_redirect = redirect;
  assign o_redirect_pc = redirect_pc;
  assign o_isa_mode_bit = isa_mode;
  assign o_addr_error = addr_error;
  assign o_reserved_instr = resv;
  assign o_flush_younger = flush;
  // Stalling in the drain state keeps the target from being fetched with
  // stale translation or coprocessor state.
  assign o_fetch_stall = (state == jrhb_pkg::JRHB_DRAIN);
  assign o_link_we = link_we;
  assign o_link_reg = link_reg;
  assign o_busy = (state != jrhb_pkg::JRHB_IDLE);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_SLOT_THEN_REDIRECT: assert property (
    state == jrhb_pkg::JRHB_SLOT && i_instr_valid && !barrier
    |=> o_redirect && o_flush_younger)
    else $error("Plain jump did not redirect after its delay slot.");

  AST_PLAIN_PC: assert property (
    $rose(o_redirect) && !$past(compressed, 1) && !$past(barrier, 1)
    |-> o_redirect_pc == $past(temp, 1))
    else $error("Uncompressed target differs from the source value.");

  AST_MISALIGN_PLAIN: assert property (
    o_redirect && !$past(compressed, 1)
    |-> o_addr_error == (o_redirect_pc[1:0] != 2'h0))
    else $error("Alignment fault wrong without compressed set.");

  AST_MODE_BIT0: assert property (
    o_redirect && $past(compressed, 1)
    |-> o_redirect_pc[0] == 1'b0 && o_isa_mode_bit == $past(temp[0], 1))
    else $error("Mode bit or cleared bit 0 wrong with compressed set.");

  AST_MISALIGN_CMP: assert property (
    o_redirect && $past(compressed, 1)
    |-> o_addr_error == (!o_isa_mode_bit && o_redirect_pc[1]))
    else $error("Alignment fault wrong with compressed set.");

  AST_NO_FETCH_PENDING: assert property (
    state == jrhb_pkg::JRHB_DRAIN && !hz_clear |=> !o_redirect)
    else $error("Target fetched while older hazard writes pending.");

  AST_DRAIN_STALLS: assert property (
    state == jrhb_pkg::JRHB_DRAIN |-> o_fetch_stall && !o_redirect)
    else $error("Fetch not stalled while draining hazards.");

  AST_HINT_PLAIN: assert property (
    is_jump && state == jrhb_pkg::JRHB_IDLE &&
    i_instr[`JRHB_SA_MSB:`JRHB_SA_LSB] == `JRHB_HINT_PLAIN
    |=> ##1 !o_fetch_stall)
    else $error("Plain hint jump stalled fetch for hazards.");

  // Only the snapshot may raise the count that the barrier waits on.
  AST_SLOT_WRITE_IGNORED: assert property (
    hz_clear && !snapshot |=> hz_clear)
    else $error("A write younger than the jump was waited for.");

  AST_SLOT_CTI: assert property (
    state == jrhb_pkg::JRHB_SLOT && i_instr_valid && i_release6 &&
    is_ctl_xfer(i_instr) |=> o_reserved_instr)
    else $error("Control transfer in delay slot not rejected.");

  AST_NO_LINK_RD0: assert property (
    is_jump && state == jrhb_pkg::JRHB_IDLE && rd_field == 5'h00
    |=> !o_link_we ##1 !o_link_we)
    else $error("Link written for a destination of zero.");

  AST_LINK_WRITE: assert property (
    is_jump && state == jrhb_pkg::JRHB_IDLE && rd_field != 5'h00
    |=> o_link_we && o_link_reg == $past(rd_field, 1))
    else $error("Link write missing for a nonzero destination.");

endmodule : jrhb_jump_ctrl

// File: tb/tb_jump_register_hazard_barrier.sv
// Self-checking bench for the register jump and hazard barrier block.
// Assumes the constants header is on the include path; drives ports only.
`timescale 1ns/1ps
`include "jrhb_regs.svh"

module tb_jump_register_hazard_barrier;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [31:0] i_instr = 32'h00000000;
  logic [31:0] i_src_value = 32'h00000000;
  logic i_release6 = 1'b0;
  logic [1:0] i_compressed_set_cfg = 2'h0;
  logic i_code_compress_cfg = 1'b0;
  logic i_hz_issue = 1'b0;
  logic i_hz_done = 1'b0;
  logic [4:0] o_src_reg_sel, o_link_reg;
  logic [31:0] o_redirect_pc;
  logic o_redirect, o_isa_mode_bit, o_addr_error, o_reserved_instr;
  logic o_flush_younger, o_fetch_stall, o_link_we, o_busy;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h00009A52;
  logic [31:0] cor [5] = '{32'h00000000, 32'h00000001, 32'h00000002,
                            32'h00000003, 32'hFFFFFFFE};
  logic [31:0] control_transfer [8] = '{32'h00000008, 32'h00000009, 32'h04110001,
                            32'h42000018, 32'h4200001F, 32'h42000020,
                            32'h00000140, 32'h0C000000};

  jrhb_jump_ctrl #(.CNT_W(4)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_src_value(i_src_value), .i_release6(i_release6),
    .i_compressed_set_cfg(i_compressed_set_cfg),
    .i_code_compress_cfg(i_code_compress_cfg), .i_hz_issue(i_hz_issue),
    .i_hz_done(i_hz_done), .o_src_reg_sel(o_src_reg_sel),
    .o_redirect(o_redirect), .o_redirect_pc(o_redirect_pc),
    .o_isa_mode_bit(o_isa_mode_bit), .o_addr_error(o_addr_error),
    .o_reserved_instr(o_reserved_instr), .o_flush_younger(o_flush_younger),
    .o_fetch_stall(o_fetch_stall), .o_link_we(o_link_we),
    .o_link_reg(o_link_reg), .o_busy(o_busy));

  always #12.5 i_clk = ~i_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] mk(input logic [5:0] fn,
                                     input logic [4:0] rd, input logic hb,
                                     input logic [4:0] rs);
    return {`JRHB_OPC_A, rs, `JRHB_REG_ZERO, rd, hb, 4'h0, fn};
  endfunction : mk

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Every input change lands 2 ns after a rising edge, clear of sampling.
  task automatic cyc(input logic v, input logic [31:0] ins,
                     input logic [31:0] src, input logic iss,
                     input logic dn);
    @(posedge i_clk);
    #2;
    i_instr_valid = v;
    i_instr = ins;
    i_src_value = src;
    i_hz_issue = iss;
    i_hz_done = dn;
  endtask : cyc

  task automatic do_jump(input logic r6, input logic [1:0] cf,
                         input logic cc, input logic [31:0] ins,
                         input logic [31:0] src, input logic [31:0] slot,
                         input logic iss, input logic rsv);
    logic comp;
    int i;
    comp = (cf != 2'h0) | cc;
    i_release6 = r6;
    i_compressed_set_cfg = cf;
    i_code_compress_cfg = cc;
    cyc(1'b1, ins, src, 1'b0, 1'b0);
    #1;
    chk("src_sel", o_src_reg_sel, ins[25:21]);
    cyc(1'b1, slot, xs(), iss, 1'b0);
    chk("busy", o_busy, 1'b1);
    chk("link_we", o_link_we, ins[15:11] != 5'h00);
    if (ins[15:11] != 5'h00)
      chk("link_reg", o_link_reg, ins[15:11]);
    cyc(1'b0, xs(), xs(), 1'b0, 1'b0);
    chk("reserved", o_reserved_instr, rsv);
    if (rsv) begin
      for (i = 0; i < 8 && o_busy !== 1'b0; i++)
        cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
      if (o_busy !== 1'b0) begin
        chk("busy_timeout", o_busy, 1'b0);
        stop_test();
      end else begin
        return;
      end
    end
    chk("redirect", o_redirect, 1'b1);
    chk("flush", o_flush_younger, 1'b1);
    chk("pc", o_redirect_pc,
        comp ? {src[31:1], 1'b0} : src);
    chk("mode", o_isa_mode_bit, comp & src[0]);
    chk("addr_err", o_addr_error, comp ? (~src[0] & src[1])
        : (src[1:0] != 2'h0));
    cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
    chk("redirect_end", o_redirect, 1'b0);
  endtask : do_jump

  initial begin
    int i;
    int n;
    logic [31:0] r;
    logic [5:0] fn;
    repeat (12) @(posedge i_clk);
    #2;
    i_sys_rst = 1'b0;
    chk("rst_pc", o_redirect_pc, 32'h00000000);
    chk("rst_busy", {o_busy, o_fetch_stall, o_redirect}, 32'h0);
    // Corners on an uncompressed core, then compressed, then random.
    for (i = 0; i < 24; i++) begin
      r = xs();
      fn = (r[0] | r[11]) ? `JRHB_FN_JUMP_LINK_REG : `JRHB_FN_JUMP_REG;
      do_jump(r[0], (i < 10) ? 2'h0 : r[2:1], (i < 5) ? 1'b0 :
              ((i < 10) ? 1'b1 : r[3]),
              mk(fn, (fn == `JRHB_FN_JUMP_LINK_REG) ? r[10:6] : 5'h00,
                 r[4], r[16:12]),
              (i < 10) ? cor[i % 5] : xs(), 32'h00000000, 1'b0,
              1'b0);
    end
    // A plain jump does not wait for an older pending write.
    cyc(1'b0, 32'h00000000, 32'h00000000, 1'b1, 1'b0);
    do_jump(1'b0, 2'h0, 1'b0, mk(`JRHB_FN_JUMP_REG, 5'h00, 1'b0, 5'h1F),
            32'h00001000, 32'h00000000, 1'b0, 1'b0);
    cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b1);
    // A write issued by the delay slot itself is not waited for.
    do_jump(1'b1, 2'h0, 1'b0, mk(`JRHB_FN_JUMP_LINK_REG, 5'h00, 1'b1,
            5'h03), 32'h00002000, 32'h00000000, 1'b1, 1'b0);
    cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b1);
    // Barrier with older writes: stall until each write lands.
    for (int k = 0; k < 4; k++) begin
      n = 1 + (xs() % 3);
      repeat (n) cyc(1'b0, 32'h00000000, 32'h00000000, 1'b1, 1'b0);
      cyc(1'b1, mk(`JRHB_FN_JUMP_LINK_REG, 5'h00, 1'b1, 5'h04),
          32'h00003004, 1'b0, 1'b0);
      cyc(1'b1, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
      cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
      chk("hb_redirect", o_redirect, 1'b0);
      chk("hb_flush", o_flush_younger, 1'b1);
      for (i = 0; i < n; i++) begin
        cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b1);
        chk("hb_stall", o_fetch_stall, 1'b1);
      end
      cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
      chk("hb_wait", o_redirect, 1'b0);
      cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
      chk("hb_go", o_redirect, 1'b1);
      chk("hb_stall_off", o_fetch_stall, 1'b0);
      chk("hb_pc", o_redirect_pc, 32'h00003004);
    end
    // The older register jump encoding does not start a jump in the
    // newer form.
    cyc(1'b1, mk(`JRHB_FN_JUMP_REG, 5'h00, 1'b1, 5'h06), 32'h00005000,
        1'b0, 1'b0);
    cyc(1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
    chk("r6_old_jump", o_busy, 1'b0);
    // Register jumps, a jump, a regimm branch, both returns, wait and pause in a delay slot are refused.
    for (i = 0; i < 8; i++)
      do_jump(1'b1, 2'h0, 1'b0, mk(`JRHB_FN_JUMP_LINK_REG, 5'h00, 1'b0,
              5'h05), 32'h00004000, control_transfer[i], 1'b0, 1'b1);
    stop_test();
  end
endmodule : tb_jump_register_hazard_barrier
